/* hw/clock_control.sv */
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "clock_control_defines.svh"

module clock_control #(
    parameter int WAKE_CYCLES = `WAKE_CYCLES,
    parameter int REF_DIV = 16
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pll_locked,
    input wire logic osc_lost,
    input wire logic xtal_tick,
    input wire logic [1:0] irq_pins,
    input wire logic lowpower_request,
    output logic clock_reset_request_q,
    output logic output_clock,
    output logic timebase_tick_q,
    output logic decrementer_tick_q,
    output logic clocks_stopped_q,
    output logic lowpower_active_q
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [2:0] lock_q;
    logic [2:0] lock_d;
    logic [31:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    clock_control_pkg::power_state_t state_q;
    clock_control_pkg::power_state_t state_d;
    logic [15:0] wake_cnt_q;
    logic [15:0] wake_cnt_d;
    logic [1:0] tb_div_q;
    logic clk_reset_q;
    logic aw_take;
    logic w_take;
    logic do_write;
    logic hit_ctrl;
    logic hit_lock;
    logic [31:0] byte_mask;
    logic [31:0] field_lock_mask;
    logic [31:0] ctrl_wmask;
    logic [31:0] lock_word;
    logic rd_ctrl;
    logic rd_lock;
    logic [31:0] rd_word;
    logic [31:0] status_word;
    logic [1:0] mode;
    logic wake_event;
    logic clocks_run;
    logic tb_source_tick;
    logic tb_tick;
    logic clk_reset_cause;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------

    // Write address and data are taken independently and paired afterwards.
    assign aw_take = s_axi_awvalid && awready_q;
    assign w_take = s_axi_wvalid && wready_q;
    assign do_write = !awready_q && !wready_q && !bvalid_q;
    assign hit_ctrl = (awaddr_q == `CTRL_ADDR);
    assign hit_lock = (awaddr_q == `LOCK_ADDR);
    assign byte_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign rd_ctrl = (s_axi_araddr == `CTRL_ADDR);
    assign rd_lock = (s_axi_araddr == `LOCK_ADDR);

    // ------------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------------

    // Locked fields are dropped from the write mask; reserved bits never pass.
    assign field_lock_mask = (lock_q[2] ? `MULT_FIELD_MASK : 32'h00000000)
        | (lock_q[1] ? `MODE_FIELD_MASK : 32'h00000000)
        | (lock_q[0] ? `PRESC_FIELD_MASK : 32'h00000000);
    assign ctrl_wmask = `CTRL_WMASK & byte_mask & ~field_lock_mask;
    assign ctrl_d = (do_write && hit_ctrl)
        ? ((ctrl_q & ~ctrl_wmask) | (wdata_q & ctrl_wmask)) : ctrl_q;

    // Lock bits can only be set by software; writing zero leaves them alone.
    assign lock_d = (do_write && hit_lock) ? (lock_q | {
        wdata_q[`MULT_LOCK_BIT] & byte_mask[`MULT_LOCK_BIT],
        wdata_q[`MODE_LOCK_BIT] & byte_mask[`MODE_LOCK_BIT],
        wdata_q[`PRESC_LOCK_BIT] & byte_mask[`PRESC_LOCK_BIT]}) : lock_q;

    // Register sits on the keep-alive supply and answers to rst_n and to clock reset.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `CTRL_RESET;
            lock_q <= 3'h0;
        end else if (clk_reset_q) begin
            ctrl_q <= `CTRL_RESET;
            lock_q <= 3'h0;
        end else begin
            ctrl_q <= ctrl_d;
            lock_q <= lock_d;
        end
    end

    // ------------------------------------------------------------------------
    // Clock reset
    // ------------------------------------------------------------------------

    // Loss events become a clock reset only when their enable bit is set.
    assign clk_reset_cause = (!pll_locked && ctrl_q[`LOCK_LOSS_RE_BIT])
        || (osc_lost && ctrl_q[`OSC_LOSS_RE_BIT]);

    // Registered reset request; it clears its own enables on the next edge.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clk_reset_q <= 1'b0;
            clock_reset_request_q <= 1'b0;
        end else begin
            clk_reset_q <= clk_reset_cause && !clk_reset_q;
            clock_reset_request_q <= clk_reset_cause && !clk_reset_q;
        end
    end

    // ------------------------------------------------------------------------
    // Power modes
    // ------------------------------------------------------------------------
    assign mode = ctrl_q[`MODE_HI:`MODE_LO];
    assign wake_event = ctrl_q[`WAKE_MASK_BIT] && (irq_pins != 2'b00);

    // Low-power entry, interrupt wake-up and the sleep exit delay.
    always_comb begin
        state_d = state_q;
        wake_cnt_d = wake_cnt_q;
        case (state_q)
            clock_control_pkg::PWR_RUN: begin
                if (lowpower_request && mode == 2'b11) begin
                    state_d = clock_control_pkg::PWR_SLEEP;
                end else if (lowpower_request && mode != 2'b00) begin
                    state_d = clock_control_pkg::PWR_LOW;
                end
            end
            clock_control_pkg::PWR_LOW: begin
                if (wake_event) begin
                    state_d = clock_control_pkg::PWR_RUN;
                end
            end
            clock_control_pkg::PWR_SLEEP: begin
                if (wake_event) begin
                    state_d = clock_control_pkg::PWR_WAKE;
                    wake_cnt_d = 16'(WAKE_CYCLES - 1);
                end
            end
            clock_control_pkg::PWR_WAKE: begin
                if (wake_cnt_q == 16'h0000) begin
                    state_d = clock_control_pkg::PWR_RUN;
                end else begin
                    wake_cnt_d = wake_cnt_q - 16'h0001;
                end
            end
            default: begin
                state_d = clock_control_pkg::PWR_RUN;
            end
        endcase
    end

    // Power state registers and their registered indications.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= clock_control_pkg::PWR_RUN;
            wake_cnt_q <= 16'h0000;
            clocks_stopped_q <= 1'b0;
            lowpower_active_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wake_cnt_q <= wake_cnt_d;
            clocks_stopped_q <= (state_d == clock_control_pkg::PWR_SLEEP)
                || (state_d == clock_control_pkg::PWR_WAKE);
            lowpower_active_q <= (state_d != clock_control_pkg::PWR_RUN);
        end
    end

    // ------------------------------------------------------------------------
    // Time base and decrementer ticks
    // ------------------------------------------------------------------------
    assign clocks_run = !clocks_stopped_q;
    assign tb_source_tick = clocks_run && (ctrl_q[`TB_SOURCE_BIT] ? 1'b1 : xtal_tick);
    assign tb_tick = tb_source_tick && (tb_div_q == 2'(`TB_DIVIDE - 1));

    // Divide the chosen source by four and gate the decrementer copy.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tb_div_q <= 2'h0;
            timebase_tick_q <= 1'b0;
            decrementer_tick_q <= 1'b0;
        end else begin
            tb_div_q <= tb_source_tick ? tb_div_q + 2'h1 : tb_div_q;
            timebase_tick_q <= tb_tick;
            decrementer_tick_q <= tb_tick && ctrl_q[`DEC_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // Output clock
    // ------------------------------------------------------------------------
    output_clock_gen #(
        .REF_DIV(REF_DIV)
    ) u_output_clock_gen (
        .clock(clock),
        .rst_n(rst_n),
        .run(clocks_run),
        .mult_code(ctrl_q[`MULT_HI:`MULT_LO]),
        .presc_code(ctrl_q[`PRESC_HI:`PRESC_LO]),
        .tick_q(output_clock)
    );

    // ------------------------------------------------------------------------
    // Bus channels
    // ------------------------------------------------------------------------
    assign lock_word = {5'h00, lock_q, 24'h000000};
    assign status_word = {22'h000000, state_q, 6'h00, pll_locked, osc_lost};
    assign rd_word = rd_ctrl ? (ctrl_q & `CTRL_WMASK) : (rd_lock ? (lock_word | status_word)
        : 32'h00000000);

    // Write channels: one write at a time, response one edge after both parts.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            awaddr_q <= 32'h00000000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                awready_q <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wready_q <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q <= (hit_ctrl || hit_lock) ? 2'h0 : 2'h2;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // Read channels: data registered on the same edge that the address is taken.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= 2'h0;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= (rd_ctrl || rd_lock) ? 2'h0 : 2'h2;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule

/* hw/clock_control_defines.svh */
`ifndef CLOCK_CONTROL_DEFINES_SVH
`define CLOCK_CONTROL_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define CTRL_ADDR 32'h8007fc50
`define LOCK_ADDR 32'h8007fc54

// ----------------------------------------------------------------------------
// Control register fields, bit 0 is the least significant bit
// ----------------------------------------------------------------------------
`define WAKE_MASK_BIT 28
`define TB_SOURCE_BIT 27
`define DEC_ENABLE_BIT 26
`define LOCK_LOSS_RE_BIT 25
`define OSC_LOSS_RE_BIT 24
`define MULT_HI 22
`define MULT_LO 19
`define MODE_HI 9
`define MODE_LO 8
`define PRESC_HI 3
`define PRESC_LO 0
`define CTRL_RESET 32'h04100003
`define CTRL_WMASK 32'h1f78030f
`define MULT_FIELD_MASK 32'h00780000
`define MODE_FIELD_MASK 32'h00000300
`define PRESC_FIELD_MASK 32'h0000000f

// ----------------------------------------------------------------------------
// Lock and status register fields
// ----------------------------------------------------------------------------
`define MULT_LOCK_BIT 26
`define MODE_LOCK_BIT 25
`define PRESC_LOCK_BIT 24
`define STATE_HI 9
`define STATE_LO 8
`define PLL_LOCKED_BIT 1
`define OSC_LOST_BIT 0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLOCK_PERIOD_NS 10
`define XTAL_STARTUP_NS 10000
`define PLL_LOCK_NS 50000
`define WAKE_CYCLES ((`XTAL_STARTUP_NS + `PLL_LOCK_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define TB_DIVIDE 4
`define MULT_BASE 4
`define PRESC_MAX_CODE 9

`endif

/* hw/clock_control_pkg.sv */
package clock_control_pkg;

    // Power state of the block.
    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_LOW = 2'b01,
        PWR_SLEEP = 2'b10,
        PWR_WAKE = 2'b11
    } power_state_t;

    // Multiplier from the low three bits of the multiplier field.
    function automatic logic [3:0] multiplier_of(input logic [3:0] code);
        multiplier_of = {1'b0, code[2:0]} + 4'h4;
    endfunction

    // Prescaler exponent: codes above nine all divide by 1024.
    function automatic logic [3:0] prescale_shift_of(input logic [3:0] code);
        prescale_shift_of = (code > 4'h9) ? 4'ha : code;
    endfunction

endpackage

/* hw/output_clock_gen.sv */
`timescale 1ns/1ps
`include "clock_control_defines.svh"

module output_clock_gen #(
    parameter int REF_DIV = 16
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [3:0] mult_code,
    input wire logic [3:0] presc_code,
    output logic tick_q
);

    logic [15:0] acc_q;
    logic [15:0] acc_d;
    logic [15:0] sum;
    logic [15:0] threshold;
    logic fire;

    // Rate is clock * multiplier / (REF_DIV * 2^shift), by a phase accumulator.
    assign threshold = 16'(REF_DIV) << clock_control_pkg::prescale_shift_of(presc_code);
    assign sum = acc_q + {12'h000, clock_control_pkg::multiplier_of(mult_code)};
    assign fire = run && (sum >= threshold);
    assign acc_d = !run ? acc_q : (fire ? sum - threshold : sum);

    // Accumulator and output enable pulse.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            tick_q <= fire;
        end
    end

endmodule

/* tb/clock_control_checker.sv */
`timescale 1ns/1ps
// ------
// Checker
// ------
module clock_control_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic pll_locked,
    input wire logic osc_lost,
    input wire logic clock_reset_request_q,
    input wire logic output_clock,
    input wire logic timebase_tick_q,
    input wire logic decrementer_tick_q,
    input wire logic clocks_stopped_q
);
    // All checks share the one clock and the asynchronous reset.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // Bus answers and the internal clock reset.
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_read_refuse: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
        else $error("second read accepted");
    chk_reset_cause: assert property (
        clock_reset_request_q |-> $past(!pll_locked || osc_lost))
        else $error("clock reset without a loss event");
    chk_reset_single: assert property (
        clock_reset_request_q |=> !clock_reset_request_q) else $error("clock reset repeated");

    // Tick gating and sleep behaviour.
    chk_dec_gated: assert property (decrementer_tick_q |-> timebase_tick_q)
        else $error("decrementer tick without time base tick");
    chk_tb_spacing: assert property (timebase_tick_q |=> !timebase_tick_q [*3])
        else $error("time base ticks too close");
    chk_sleep_still: assert property (
        clocks_stopped_q && $past(clocks_stopped_q) |->
        !(output_clock || timebase_tick_q || decrementer_tick_q))
        else $error("tick while clocks stopped");
    chk_sleep_exit: assert property ($rose(clocks_stopped_q) |-> clocks_stopped_q [*8])
        else $error("sleep left too soon");

    cover property (clock_reset_request_q);
    cover property ($rose(clocks_stopped_q));
    cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'b10);
endmodule

bind clock_control clock_control_checker checker_inst (.clock, .rst_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .pll_locked,
    .osc_lost, .clock_reset_request_q, .output_clock, .timebase_tick_q,
    .decrementer_tick_q, .clocks_stopped_q);

/* tb/clock_control_tb.sv */
`timescale 1ns/1ps
`include "clock_control_defines.svh"
module clock_control_tb;
    logic clock = 1'b0;
    logic xtal_tick = 1'b0;
    logic rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic pll_locked, osc_lost, lowpower_request, clock_reset_request_q, output_clock;
    logic timebase_tick_q, decrementer_tick_q, clocks_stopped_q, lowpower_active_q;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, irq_pins;
    int errors = 0, checks_done = 0, cyc = 0, xd = 0, oc = 0, tbc = 0, dc = 0, rq = 0;
    int a, b, c;
    int ps[3] = '{1, 9, 15};

    clock_control #(.WAKE_CYCLES(8), .REF_DIV(16)) dut (.clock, .rst_n, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pll_locked, .osc_lost, .xtal_tick, .irq_pins, .lowpower_request,
        .clock_reset_request_q, .output_clock, .timebase_tick_q, .decrementer_tick_q,
        .clocks_stopped_q, .lowpower_active_q);

    // The clock toggles every 5 ns.
    always #5 clock = ~clock;

    // Counts cycles and pulses, makes a crystal tick every tenth cycle, cuts a hang short.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        xd <= (xd == 9) ? 0 : xd + 1;
        xtal_tick <= (xd == 9);
        oc <= oc + int'(output_clock);
        tbc <= tbc + int'(timebase_tick_q);
        dc <= dc + int'(decrementer_tick_q);
        rq <= rq + int'(clock_reset_request_q);
        if (cyc == 80000) begin
            errors++;
            finish_test();
        end
    end

    // ------
    // Tasks
    // ------
    task automatic finish_test;
        if (errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Accepts a pulse count within one of the expected value.
    task automatic near(input string nm, input int e, input int g);
        chk(nm, e, (g >= e - 1 && g <= e + 1) ? e : g);
    endtask

    // Each bus task waits one edge first, so a ready lowered by the last call is not re-raised.
    task automatic wr(input logic [31:0] ad, input logic [31:0] d, input logic [1:0] er);
        @(posedge clock);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic rc(input logic [31:0] ad, input logic [31:0] e, input logic [1:0] er);
        @(posedge clock);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        chk("rdata", e, s_axi_rdata);
    endtask

    // Counts output, time base and decrementer pulses over a window.
    task automatic meas(input int w);
        repeat (8) @(posedge clock);
        a = oc;
        b = tbc;
        c = dc;
        repeat (w) @(posedge clock);
        a = oc - a;
        b = tbc - b;
        c = dc - c;
    endtask

    // ------
    // Main sequence
    // ------
    initial begin
        rst_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hf;
        pll_locked = 1'b1;
        osc_lost = 1'b0;
        lowpower_request = 1'b0;
        irq_pins = 2'b00;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rc(`CTRL_ADDR, 32'h04100003, 2'b00);
        wr(`CTRL_ADDR, 32'hffffffff, 2'b00);
        rc(`CTRL_ADDR, 32'h1f78030f, 2'b00);
        wr(`CTRL_ADDR + 32'h8, 32'hffffffff, 2'b10);
        rc(`CTRL_ADDR + 32'h8, 32'h0, 2'b10);
        wr(`LOCK_ADDR, 32'h07000000, 2'b00);
        wr(`CTRL_ADDR, 32'h0, 2'b00);
        rc(`CTRL_ADDR, 32'h0078030f, 2'b00);
        for (int k = 0; k < 4; k++) begin
            wr(`CTRL_ADDR, k[0] ? (k[1] ? 32'h02000000 : 32'h01000000) : 32'h0, 2'b00);
            c = rq;
            if (k[1]) pll_locked <= 1'b0;
            else osc_lost <= 1'b1;
            repeat (6) @(posedge clock);
            pll_locked <= 1'b1;
            osc_lost <= 1'b0;
            repeat (3) @(posedge clock);
            chk("reset pulses", c + k[0], rq);
            if (k[0]) rc(`CTRL_ADDR, 32'h04100003, 2'b00);
        end
        rc(`LOCK_ADDR, 32'h00000002, 2'b00);
        for (int m = 0; m < 16; m++) begin
            wr(`CTRL_ADDR, 32'(m) << 19, 2'b00);
            meas(64);
            near("output clock", 4 * ((m % 8) + 4), a);
        end
        foreach (ps[i]) begin
            wr(`CTRL_ADDR, 32'h00380000 | 32'(ps[i]), 2'b00);
            meas(32 << ((ps[i] > 9) ? 10 : ps[i]));
            near("output clock", 22, a);
        end
        for (int k = 0; k < 4; k++) begin
            wr(`CTRL_ADDR, 32'(k) << 26, 2'b00);
            meas(400);
            near("timebase", k[1] ? 100 : 10, b);
            near("decrementer", k[0] ? (k[1] ? 100 : 10) : 0, c);
        end
        for (int md = 0; md < 4; md++) begin
            wr(`CTRL_ADDR, 32'h08000000 | (32'(md) << 8), 2'b00);
            lowpower_request <= 1'b1;
            @(posedge clock);
            lowpower_request <= 1'b0;
            meas(40);
            near("sleep ticks", md == 3 ? 0 : 10, b);
            chk("low power", md != 0, lowpower_active_q);
            chk("stopped", md == 3, clocks_stopped_q);
            irq_pins <= md[0] ? 2'b01 : 2'b10;
            repeat (4) @(posedge clock);
            chk("masked wake", md != 0, lowpower_active_q);
            wr(`CTRL_ADDR, 32'h18000000 | (32'(md) << 8), 2'b00);
            for (int n = 0; n < 40 && lowpower_active_q; n++) @(posedge clock);
            irq_pins <= 2'b00;
            chk("woken", 0, lowpower_active_q);
        end
        finish_test();
    end
endmodule
